// ### design/rcio_pkg.sv
// Constants and types shared by the remote parallel control block
// Function
// - Remote select closed enables request pin
// - Closed request switches high voltage on
// - Request closed-to-open clears latched errors
// - Open safety loop forces output off
// - Status outputs are open-collector pull-downs
// - Power status low while powered on
// - High-voltage status low while output on
// - Control-source output low in local mode
// - Run status low in steady running
// - First threshold output low below threshold
// - Second threshold output low, independent
// - Fault output low unless error active
// - Scale switch picks linear or logarithmic
// - Log output twice log difference, 8 V
// - Ground fault latches code, stops operation
// - Bypass switch ignores ground fault
// - Indicator blinks continuously after power-up
// - Soft start done below threshold enters run
// - Remote mode ignores keys except power
package rcio_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned DEB_TIME_NS = 1000000;
    localparam int unsigned DEB_CYCLES = DEB_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_TIME_NS = 500000000;
    localparam int unsigned BLINK_CYCLES = BLINK_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_THR1 = 8'h08;
    localparam logic [7:0] ADDR_THR2 = 8'h0c;
    localparam logic [7:0] ADDR_ANALOG = 8'h10;
    localparam logic [7:0] ADDR_LOGZERO = 8'h14;
    localparam logic [7:0] ADDR_ERRCLR = 8'h18;
    localparam int unsigned CTRL_POWER = 0;
    localparam int unsigned CTRL_SERIAL_HV = 1;
    localparam int unsigned CTRL_REMOTE = 2;
    localparam logic signed [15:0] THR_RESET = 16'shf830;
    localparam logic signed [15:0] LOGZERO_RESET = 16'shd8f0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Analog scaling and pins
    // ----------------------------------------
    localparam logic [15:0] LIN_DIV = 16'h0003;
    localparam logic signed [17:0] LOG_FULL_MV = 18'sh01f40;
    localparam int unsigned N_OC = 7;
    localparam int unsigned PIN_POWER = 0;
    localparam int unsigned PIN_HV = 1;
    localparam int unsigned PIN_LOCAL = 2;
    localparam int unsigned PIN_RUN = 3;
    localparam int unsigned PIN_P1 = 4;
    localparam int unsigned PIN_P2 = 5;
    localparam int unsigned PIN_FAULT = 6;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN} rcio_run_t;

    typedef struct packed {
        logic awvalid; logic [7:0] awaddr;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [7:0] araddr;
        logic rready;
    } rcio_axil_req_t;

    typedef struct packed {
        logic awready; logic wready;
        logic bvalid; logic [1:0] bresp;
        logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } rcio_axil_rsp_t;

    typedef struct packed {
        logic [N_OC-1:0] out;
        logic [N_OC-1:0] oe;
    } rcio_oc_t;

    typedef struct packed {
        logic remote; logic power; logic hv; logic run;
        logic p1; logic p2; logic err_loop; logic err_ground; logic err_run;
        logic sel; logic req; logic scale_log; logic blink;
    } rcio_status_t;

endpackage : rcio_pkg

// ### design/rcio_debounce.sv
// Two-flop synchroniser with stable-count debounce for one level input
`timescale 1ns/1ps
module rcio_debounce
    import rcio_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = DEB_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Level in and clean level out
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1; logic s2; logic out; logic [31:0] cnt;
    } rcio_deb_st_t;

    rcio_deb_st_t s;
    rcio_deb_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = din;
        next_s.s2 = s.s1;
        // Only the second flop is compared; the first may be metastable
        if (s.s2 == s.out) begin
            next_s.cnt = 32'h0;
        end else if (s.cnt >= STABLE_CYCLES - 1) begin
            next_s.out = s.s2;
            next_s.cnt = 32'h0;
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.out;

endmodule : rcio_debounce

// ### design/rcio_remote_io.sv
// Remote parallel control connector logic with register access
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rcio_remote_io
    import rcio_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = DEB_CYCLES,
    parameter int unsigned BLINK_HALF_CYCLES = BLINK_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire rcio_axil_req_t req,
    output rcio_axil_rsp_t rsp,
    // Remote connector inputs, high when closed to the supply pin
    input wire logic control_source_select_in,
    input wire logic high_voltage_request,
    input wire logic safety_loop_in,
    // Remote connector status outputs
    output rcio_oc_t pins,
    // Rear switches
    input wire logic scale_log_sel,
    input wire logic ground_fault_bypass,
    // Front panel keys, one-cycle pulses
    input wire logic key_power,
    input wire logic key_hv,
    input wire logic key_remote,
    // Supply and measurement
    input wire logic ground_fault_in,
    input wire logic run_fault_in,
    input wire logic current_below_in,
    input wire logic [15:0] current_ua,
    input wire logic signed [15:0] log_pressure,
    // Indications
    output logic high_voltage_on,
    output logic loop_open_code,
    output logic ground_fault_code,
    output logic [15:0] analog_mv,
    output logic panel_blink
);

    typedef struct packed {
        logic aw_got; logic [7:0] aw_addr;
        logic w_got; logic [31:0] w_data; logic [3:0] w_strb;
        logic bvalid; logic [1:0] bresp;
        logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
        logic power; logic serial_hv; logic remote; logic local_hv;
        logic signed [15:0] thr1;
        logic signed [15:0] thr2;
        logic signed [15:0] log_zero;
        logic err_ground; logic err_run; logic req_prev;
        logic hv; rcio_run_t run_st;
        logic p1; logic p2;
        logic [15:0] ana;
        logic [31:0] blink_cnt; logic blink;
    } rcio_state_t;

    rcio_state_t s;
    rcio_state_t next_s;

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    logic [2:0] raw_in;
    logic [2:0] clean_in;
    logic sel_c;
    logic req_c;
    logic loop_c;

    assign raw_in = {safety_loop_in, high_voltage_request, control_source_select_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_deb
            rcio_debounce #(
                .STABLE_CYCLES(DEBOUNCE_CYCLES)
            ) u_deb (
                .aclk(aclk),
                .aresetn(aresetn),
                .din(raw_in[gi]),
                .dout(clean_in[gi])
            );
        end
    endgenerate

    assign sel_c = clean_in[0];
    assign req_c = clean_in[1];
    assign loop_c = clean_in[2];

    // ----------------------------------------
    // Derived levels
    // ----------------------------------------
    logic err_any;
    logic par_sel;
    rcio_status_t status;

    // open loop counts as an active error
    assign err_any = s.err_ground | s.err_run | !loop_c;
    // request pin only steers in remote mode with select closed
    assign par_sel = s.remote & sel_c;

    always_comb begin
        status = '0;
        status.remote = s.remote;
        status.power = s.power;
        status.hv = s.hv;
        status.run = (s.run_st == ST_RUN);
        status.p1 = s.p1;
        status.p2 = s.p2;
        status.err_loop = !loop_c;
        status.err_ground = s.err_ground;
        status.err_run = s.err_run;
        status.sel = sel_c;
        status.req = req_c;
        status.scale_log = scale_log_sel;
        status.blink = s.blink;
    end

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic hv_cmd;
    logic clr_err;
    logic signed [17:0] log_diff;
    logic [15:0] lin_mv;

    always_comb begin
        next_s = s;
        hv_cmd = 1'b0;
        clr_err = 1'b0;
        log_diff = 18'sh0;
        lin_mv = 16'h0;

        // Register bus: address and data may arrive in either order
        if (req.awvalid && !s.aw_got && !s.bvalid) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = req.awaddr;
        end
        if (req.wvalid && !s.w_got && !s.bvalid) begin
            next_s.w_got = 1'b1;
            next_s.w_data = req.wdata;
            next_s.w_strb = req.wstrb;
        end
        if (s.bvalid && req.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            case (s.aw_addr)
                ADDR_CTRL: begin
                    if (s.w_strb[0]) begin
                        next_s.power = s.w_data[CTRL_POWER];
                        next_s.serial_hv = s.w_data[CTRL_SERIAL_HV];
                        next_s.remote = s.w_data[CTRL_REMOTE];
                    end
                end
                ADDR_THR1: next_s.thr1 = merge16(s.thr1, s.w_data, s.w_strb);
                ADDR_THR2: next_s.thr2 = merge16(s.thr2, s.w_data, s.w_strb);
                ADDR_LOGZERO: next_s.log_zero = merge16(s.log_zero, s.w_data, s.w_strb);
                ADDR_ERRCLR: clr_err = s.w_strb[0] & s.w_data[0];
                ADDR_STATUS, ADDR_ANALOG: begin
                end
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end

        if (s.rvalid && req.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (req.arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = 32'h0;
            case (req.araddr)
                ADDR_CTRL: begin
                    next_s.rdata[CTRL_POWER] = s.power;
                    next_s.rdata[CTRL_SERIAL_HV] = s.serial_hv;
                    next_s.rdata[CTRL_REMOTE] = s.remote;
                end
                ADDR_STATUS: next_s.rdata = 32'(status);
                ADDR_THR1: next_s.rdata = {16'h0, s.thr1};
                ADDR_THR2: next_s.rdata = {16'h0, s.thr2};
                ADDR_ANALOG: next_s.rdata = {16'h0, s.ana};
                ADDR_LOGZERO: next_s.rdata = {16'h0, s.log_zero};
                ADDR_ERRCLR: next_s.rdata = 32'h0;
                default: next_s.rresp = RESP_SLVERR;
            endcase
        end

        // Front panel keys; the power key also acknowledges errors
        if (key_power) begin
            if (err_any) begin
                clr_err = 1'b1;
            end else begin
                next_s.power = !s.power;
            end
        end
        // only the power key works in remote mode
        if (!s.remote) begin
            if (key_hv) begin
                next_s.local_hv = !s.local_hv;
            end
            if (key_remote) begin
                next_s.remote = 1'b1;
            end
        end

        // release of the request pin clears latched errors
        next_s.req_prev = req_c;
        if (par_sel && s.req_prev && !req_c) begin
            clr_err = 1'b1;
        end
        if (clr_err) begin
            next_s.err_ground = 1'b0;
            next_s.err_run = 1'b0;
        end
        if (ground_fault_in && !ground_fault_bypass && s.power) begin
            next_s.err_ground = 1'b1;
        end
        if (run_fault_in && s.run_st != ST_OFF) begin
            next_s.err_run = 1'b1;
        end

        // A latched stop drops the local request so recovery needs a new key press
        if (next_s.err_ground || next_s.err_run || !loop_c || !next_s.power) begin
            next_s.local_hv = 1'b0;
        end

        // source selection; request level drives output in remote mode with select closed
        if (next_s.remote) begin
            hv_cmd = sel_c ? req_c : next_s.serial_hv;
        end else begin
            hv_cmd = next_s.local_hv;
        end
        // safety loop and any latched error force output off
        next_s.hv = next_s.power & hv_cmd & loop_c & !next_s.err_ground & !next_s.err_run;

        // soft start ends once current falls below threshold
        case (s.run_st)
            ST_OFF: begin
                if (next_s.hv) begin
                    next_s.run_st = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (!next_s.hv) begin
                    next_s.run_st = ST_OFF;
                end else if (current_below_in) begin
                    next_s.run_st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!next_s.hv) begin
                    next_s.run_st = ST_OFF;
                end
            end
            default: next_s.run_st = ST_OFF;
        endcase

        next_s.p1 = (log_pressure < s.thr1);
        next_s.p2 = (log_pressure < s.thr2);

        // scale switch; log output clamped to 8 V
        lin_mv = current_ua / LIN_DIV;
        log_diff = 18'(2 * (18'(log_pressure) - 18'(s.log_zero)));
        if (!scale_log_sel) begin
            next_s.ana = lin_mv;
        end else if (log_diff < 18'sh0) begin
            next_s.ana = 16'h0;
        end else if (log_diff > LOG_FULL_MV) begin
            next_s.ana = 16'(LOG_FULL_MV);
        end else begin
            next_s.ana = 16'(log_diff);
        end

        // indicator toggles forever while the control logic runs
        if (s.blink_cnt >= BLINK_HALF_CYCLES - 1) begin
            next_s.blink_cnt = 32'h0;
            next_s.blink = !s.blink;
        end else begin
            next_s.blink_cnt = s.blink_cnt + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.run_st <= ST_OFF;
            s.thr1 <= THR_RESET;
            s.thr2 <= THR_RESET;
            s.log_zero <= LOGZERO_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        rsp.awready = !s.aw_got && !s.bvalid;
        rsp.wready = !s.w_got && !s.bvalid;
        rsp.bvalid = s.bvalid;
        rsp.bresp = s.bresp;
        rsp.arready = !s.rvalid;
        rsp.rvalid = s.rvalid;
        rsp.rdata = s.rdata;
        rsp.rresp = s.rresp;
    end

    always_comb begin
        // transistor conducts only to pull the line low
        pins.out = '0;
        pins.oe[PIN_POWER] = s.power;
        pins.oe[PIN_HV] = s.hv;
        pins.oe[PIN_LOCAL] = !s.remote;
        pins.oe[PIN_RUN] = (s.run_st == ST_RUN);
        pins.oe[PIN_P1] = s.p1;
        pins.oe[PIN_P2] = s.p2;
        pins.oe[PIN_FAULT] = !err_any;
    end

    assign high_voltage_on = s.hv;
    assign loop_open_code = !loop_c;
    assign ground_fault_code = s.err_ground;
    assign analog_mv = s.ana;
    assign panel_blink = s.blink;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_req_close;
        par_sel && s.power && !err_any && !req_c ##1
            par_sel && s.power && !err_any && req_c && !ground_fault_in && !run_fault_in;
    endsequence

    sequence s_soft_done;
        s.run_st == ST_SOFT && current_below_in ##1 s.hv;
    endsequence

    a_req_turns_on: assert property (s_req_close |=> s.hv)
        else $error("closed request did not turn output on");
    a_loop_forces_off: assert property (!loop_c |=> !s.hv && !pins.oe[PIN_HV])
        else $error("output on with safety loop open");
    a_req_fall_clears: assert property (par_sel && s.req_prev && !req_c && !run_fault_in |=> !s.err_run)
        else $error("request release did not clear error");
    a_ground_latch: assert property (ground_fault_in && !ground_fault_bypass && s.power |=> s.err_ground[*2])
        else $error("ground fault not latched");
    a_bypass_ignores: assert property ($rose(s.err_ground) |-> $past(!ground_fault_bypass))
        else $error("ground error raised while bypassed");
    a_soft_to_run: assert property (s_soft_done |-> pins.oe[PIN_RUN])
        else $error("run status missing after soft start");
    a_hv_pin: assert property ($rose(s.hv) |-> pins.oe[PIN_HV] && pins.oe[PIN_POWER])
        else $error("high voltage status not pulled low");
    a_local_pin: assert property ($fell(s.remote) |-> pins.oe[PIN_LOCAL])
        else $error("local status not pulled low");
    a_fault_pin: assert property (s.err_ground || s.err_run || !loop_c |-> !pins.oe[PIN_FAULT])
        else $error("fault output held low during error");
    a_p1_compare: assert property (log_pressure < s.thr1 && $stable(s.thr1) |=> pins.oe[PIN_P1])
        else $error("first threshold output not low");
    a_remote_keys: assert property (s.remote && key_hv && !s.local_hv |=> !s.local_hv)
        else $error("panel key acted in remote mode");
    a_blink_toggle: assert property (s.blink_cnt == BLINK_HALF_CYCLES - 1 |=> $changed(s.blink))
        else $error("indicator did not toggle");

endmodule : rcio_remote_io

// ### tb/rcio_ctrl_model.sv
// Behavioural model of the external controller on the remote connector
`timescale 1ns/1ps
module rcio_ctrl_model
    import rcio_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Wanted contact states from the bench
    input wire logic want_sel,
    input wire logic want_req,
    input wire logic want_loop,
    input wire logic bounce,
    // Device status outputs
    input wire rcio_oc_t pins,
    // Contact lines and pulled-up status lines
    output logic sel_line = 1'b0,
    output logic req_line = 1'b0,
    output logic loop_line = 1'b0,
    output logic [N_OC-1:0] status_line
);
    // pull-ups on open collectors
    // A released line floats up to the supply, it never keeps the last level
    always_comb begin
        for (int i = 0; i < N_OC; i++) begin
            status_line[i] = pins.oe[i] ? pins.out[i] : 1'b1;
        end
    end

    always @(posedge aclk) begin
        sel_line <= want_sel;
        loop_line <= want_loop;
        // commanded bounce toggles the contact every cycle
        if (bounce) begin
            req_line <= ~req_line;
        end else begin
            req_line <= want_req;
        end
    end
endmodule : rcio_ctrl_model

// ### tb/rcio_remote_io_tb.sv
// Self-checking bench for the remote parallel control block
`timescale 1ns/1ps
module rcio_remote_io_tb;
    import rcio_pkg::*;
    localparam int unsigned DEB = 4;
    typedef struct packed {
        logic wen; logic [7:0] a; logic [31:0] wd; logic [31:0] m; logic [31:0] e; logic [1:0] rs;
    } rcio_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    rcio_axil_req_t req = '0;
    rcio_axil_rsp_t rsp;
    rcio_oc_t pins;
    logic w_sel = 1'b0, w_req = 1'b0, w_loop = 1'b0, bounce = 1'b0;
    logic sel, hvr, loop, pb;
    logic [N_OC-1:0] line;
    logic scale = 1'b0, byp = 1'b0, key_rem = 1'b0, gnd = 1'b0, cur_below = 1'b0;
    logic [15:0] cur = 16'h0000;
    logic signed [15:0] logp = 16'sh0000;
    logic hv_on, loop_code, gnd_code, blink;
    logic [15:0] amv;
    logic [31:0] d;
    logic [1:0] r;
    int n_errors = 0;
    int num_checks = 0;
    int i, k;
    rcio_row_t rows [7] = '{
        '{1'b0, ADDR_THR1, 32'h0, 32'hffff, 32'hf830, RESP_OKAY},
        '{1'b0, ADDR_THR2, 32'h0, 32'hffff, 32'hf830, RESP_OKAY},
        '{1'b0, ADDR_LOGZERO, 32'h0, 32'hffff, 32'hd8f0, RESP_OKAY},
        '{1'b0, ADDR_CTRL, 32'h0, 32'h7, 32'h0, RESP_OKAY},
        '{1'b1, ADDR_THR1, 32'h0100, 32'hffff, 32'h0100, RESP_OKAY},
        '{1'b1, ADDR_THR2, 32'hff00, 32'hffff, 32'hff00, RESP_OKAY},
        '{1'b1, 8'h1c, 32'h5, 32'h0, 32'h0, RESP_SLVERR}
    };

    always #2.5 aclk = ~aclk;

    rcio_remote_io #(.DEBOUNCE_CYCLES(DEB), .BLINK_HALF_CYCLES(8)) rcio_remote_io_inst (
        .aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp),
        .control_source_select_in(sel), .high_voltage_request(hvr), .safety_loop_in(loop),
        .pins(pins), .scale_log_sel(scale), .ground_fault_bypass(byp),
        .key_power(1'b0), .key_hv(key_rem), .key_remote(key_rem),
        .ground_fault_in(gnd), .run_fault_in(1'b0), .current_below_in(cur_below),
        .current_ua(cur), .log_pressure(logp), .high_voltage_on(hv_on), .loop_open_code(loop_code),
        .ground_fault_code(gnd_code), .analog_mv(amv), .panel_blink(blink));

    rcio_ctrl_model rcio_ctrl_model_inst (
        .aclk(aclk), .want_sel(w_sel), .want_req(w_req), .want_loop(w_loop), .bounce(bounce),
        .pins(pins), .sel_line(sel), .req_line(hvr), .loop_line(loop), .status_line(line));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic timeout();
        n_errors++;
        $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
        results();
    endtask : timeout

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    // Waits n edges, then settles to the falling edge for sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : cyc

    // Handshakes are judged at the falling edge, which sees what the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        logic aw, w, b;
        int t;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        rs = 2'h3;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= wd;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        for (t = 0; t < 40 && !b; t++) begin
            @(negedge aclk);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            b = rsp.bvalid;
            rs = rsp.bresp;
            @(posedge aclk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
        end
        if (!b) timeout();
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] rdat, output logic [1:0] rs);
        logic ar, v;
        int t;
        ar = 1'b0;
        v = 1'b0;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (t = 0; t < 40 && !v; t++) begin
            @(negedge aclk);
            ar = req.arvalid && rsp.arready;
            v = rsp.rvalid;
            rdat = rsp.rdata;
            rs = rsp.rresp;
            @(posedge aclk);
            if (ar) req.arvalid <= 1'b0;
            if (v) req.rready <= 1'b0;
        end
        if (!v) timeout();
    endtask : rd

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[j]) begin
            if (rows[j].wen) begin
                wr(rows[j].a, rows[j].wd, r);
                chk(r, rows[j].rs);
            end
            rd(rows[j].a, d, r);
            chk(d & rows[j].m, rows[j].e);
            chk(r, rows[j].rs);
        end
        done("registers");
        @(posedge aclk);
        w_loop <= 1'b1;
        w_sel <= 1'b1;
        wr(ADDR_CTRL, 32'h5, r);
        cyc(DEB + 6);
        chk({loop_code, line[PIN_FAULT], line[PIN_LOCAL], line[PIN_POWER]}, 4'b0010);
        @(posedge aclk);
        bounce <= 1'b1;
        // A bare synchroniser would pass one of these two samples high
        cyc(5);
        chk(hv_on, 1'b0);
        cyc(0);
        chk(hv_on, 1'b0);
        @(posedge aclk);
        bounce <= 1'b0;
        cyc(DEB + 6);
        chk(hv_on, 1'b0);
        @(posedge aclk);
        w_req <= 1'b1;
        cyc(DEB + 6);
        chk({hv_on, line[PIN_HV], line[PIN_RUN]}, 3'b101);
        @(posedge aclk);
        cur_below <= 1'b1;
        cyc(3);
        chk({line[PIN_RUN], line[PIN_P1], line[PIN_P2]}, 3'b001);
        @(posedge aclk);
        logp <= 16'shfe00;
        cur <= 16'h7530;
        cyc(3);
        chk({line[PIN_P1], line[PIN_P2]}, 2'b00);
        chk(amv, 16'h2710);
        @(posedge aclk);
        scale <= 1'b1;
        logp <= 16'shdcd8;
        cyc(3);
        chk(amv, 16'h07d0);
        @(posedge aclk);
        logp <= 16'sh0000;
        cyc(3);
        chk(amv, 16'h1f40);
        done("remote run and outputs");
        @(posedge aclk);
        w_sel <= 1'b0;
        cyc(DEB + 6);
        chk(hv_on, 1'b0);
        wr(ADDR_CTRL, 32'h7, r);
        cyc(2);
        chk(hv_on, 1'b1);
        wr(ADDR_CTRL, 32'h5, r);
        @(posedge aclk);
        w_sel <= 1'b1;
        cyc(DEB + 6);
        chk(hv_on, 1'b1);
        done("source select");
        @(posedge aclk);
        w_loop <= 1'b0;
        cyc(DEB + 6);
        chk({hv_on, loop_code, line[PIN_FAULT]}, 3'b011);
        @(posedge aclk);
        w_loop <= 1'b1;
        w_req <= 1'b0;
        cyc(DEB + 6);
        @(posedge aclk);
        w_req <= 1'b1;
        cyc(DEB + 6);
        chk({hv_on, loop_code, line[PIN_FAULT]}, 3'b100);
        done("safety_loop_in");
        @(posedge aclk);
        gnd <= 1'b1;
        cyc(DEB + 6);
        @(posedge aclk);
        gnd <= 1'b0;
        cyc(DEB + 6);
        chk({hv_on, gnd_code, line[PIN_FAULT]}, 3'b011);
        @(posedge aclk);
        w_req <= 1'b0;
        cyc(DEB + 6);
        chk(gnd_code, 1'b0);
        @(posedge aclk);
        w_req <= 1'b1;
        byp <= 1'b1;
        gnd <= 1'b1;
        cyc(DEB + 6);
        chk({hv_on, gnd_code}, 2'b10);
        done("ground fault");
        @(posedge aclk);
        key_rem <= 1'b1;
        @(posedge aclk);
        key_rem <= 1'b0;
        cyc(3);
        chk(line[PIN_LOCAL], 1'b1);
        // Back in local mode, a panel key taken while remote would show as output on
        wr(ADDR_CTRL, 32'h1, r);
        cyc(2);
        chk({hv_on, line[PIN_LOCAL]}, 2'b00);
        k = 0;
        pb = blink;
        for (i = 0; i < 32; i++) begin
            @(negedge aclk);
            if (blink !== pb) k++;
            pb = blink;
        end
        chk(k >= 3 && k <= 5, 1'b1);
        done("keys and blink");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({hv_on, loop_code, line[PIN_LOCAL], line[PIN_POWER]}, 4'b0101);
        done("second reset");
        results();
    end
endmodule : rcio_remote_io_tb
